// ---- include/hccfg_cfg.svh ----
/*
 holds offsets, field positions, reset values and masks of the config header slice.
 assumes inclusion by bare name from design files (hccfg_regs); the package does not include it.
*/
`ifndef HCCFG_CFG_SVH
`define HCCFG_CFG_SVH
`define HCCFG_OFF_CACHE_LAT     8'h0c
`define HCCFG_OFF_HDR_SELFTEST  8'h0e
`define HCCFG_OFF_CTRL_WIN      8'h10
`define HCCFG_OFF_EXT_WIN       8'h14
`define HCCFG_LINE_LSB          0
`define HCCFG_LAT_LSB           8
`define HCCFG_CACHE_LAT_RST     16'h0000
`define HCCFG_HDR_SELFTEST_VAL  16'h0000
`define HCCFG_CTRL_WIN_MASK     32'hfffff800
`define HCCFG_EXT_WIN_MASK      32'hffffc000
`define HCCFG_WIN_RST           32'h00000000
`endif

// ---- include/hccfg_pkg.sv ----
/*
 holds the types of the config header slice.
 includes no header; the cfg header is used by the design files only.
*/
`default_nettype none
package hccfg_pkg;
	typedef logic [7:0]  hccfg_byte_t;
	typedef logic [31:0] hccfg_word_t;
	typedef enum logic [1:0] {
		HCCFG_IDLE    = 2'b00,
		HCCFG_COUNT   = 2'b01,
		HCCFG_EXPIRED = 2'b10
	} hccfg_lat_e;
endpackage
`default_nettype wire

// ---- rtl/hccfg_lat_timer.sv ----
/*
 initiator latency timer: counts cycles from frame start, flags expiry.
 assumes frame_start and frame_done are single-cycle, same-clock pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module hccfg_lat_timer (
	input  wire logic                 mclk,
	input  wire logic                 resetn,
	input  wire logic                 frame_start,
	input  wire logic                 frame_done,
	input  wire hccfg_pkg::hccfg_byte_t limit,
	output var  logic                 expired_r
);
	hccfg_pkg::hccfg_lat_e st_r;
	hccfg_pkg::hccfg_byte_t cnt_r;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			st_r <= hccfg_pkg::HCCFG_IDLE;
			cnt_r <= 8'h00;
		end else begin
			case (st_r)
				hccfg_pkg::HCCFG_IDLE: begin
					cnt_r <= 8'h00;
					if (frame_start) begin
						st_r <= hccfg_pkg::HCCFG_COUNT;
					end
				end
				hccfg_pkg::HCCFG_COUNT: begin
					if (frame_done) begin
						st_r <= hccfg_pkg::HCCFG_IDLE;
					end else if (cnt_r + 8'h01 >= limit) begin
						st_r <= hccfg_pkg::HCCFG_EXPIRED;
					end else begin
						cnt_r <= cnt_r + 8'h01;
					end
				end
				hccfg_pkg::HCCFG_EXPIRED: begin
					if (frame_done) begin
						st_r <= hccfg_pkg::HCCFG_IDLE;
					end
				end
				default: st_r <= hccfg_pkg::HCCFG_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			expired_r <= 1'b0;
		end else begin
			expired_r <= (st_r == hccfg_pkg::HCCFG_COUNT && !frame_done && cnt_r + 8'h01 >= limit)
				|| (st_r == hccfg_pkg::HCCFG_EXPIRED && !frame_done);
		end
	end

	sequence s_frame_open;
		st_r == hccfg_pkg::HCCFG_IDLE && frame_start && limit == 8'h03;
	endsequence

	sequence s_run_three;
		!frame_done [*3];
	endsequence

	property p_lat_count;
		@(posedge mclk) disable iff (!resetn)
		s_frame_open ##1 s_run_three |-> ##1 expired_r;
	endproperty
	a_lat_count: assert property (p_lat_count) else $error("latency expiry late");
endmodule // hccfg_lat_timer
`default_nettype wire

// ---- rtl/hccfg_regs.sv ----
/*
 config header slice: latency/line size, header/self-test, two memory windows,
 plus initiator latency termination.
 assumes a config port with byte address, byte enables, one-cycle strobes;
 reads answer one cycle later; frame/grant inputs are same-clock logic.
*/
// Overview of operation
// - latency count starts at frame, counts clocks
// - expired count ends transaction on grant removal
// - line size field writable, resets zero, used
// - self-test byte reads zero always
// - header type byte reads zero, single function
// - control window all-ones reads FFFFF800
// - control window bits 31-11 writable pointer
// - control window bits 10-4 hardwired zero
// - control window bits 3-0 read zero
// - extension window all-ones reads FFFFC000
// - extension window bits 31-14 writable pointer
// - extension window bits 13-0 read zero
`timescale 1ns/1ps
`default_nettype none
`include "hccfg_cfg.svh"
module hccfg_regs (
	input  wire logic                   mclk,
	input  wire logic                   resetn,
	input  wire logic [7:0]             cfg_addr,
	input  wire logic [3:0]             cfg_be,
	input  wire logic                   cfg_wr,
	input  wire logic                   cfg_rd,
	input  wire hccfg_pkg::hccfg_word_t cfg_wdata,
	input  wire logic                   frame_start,
	input  wire logic                   frame_done,
	input  wire logic                   gnt_active,
	output var  hccfg_pkg::hccfg_word_t cfg_rdata_r,
	output var  logic                   cfg_rvalid_r,
	output var  logic                   end_xfer_r,
	output var  hccfg_pkg::hccfg_byte_t line_burst_length_r,
	output var  hccfg_pkg::hccfg_word_t ctrl_base_r,
	output var  hccfg_pkg::hccfg_word_t ext_base_r
);
	hccfg_pkg::hccfg_byte_t lat_limit_r;
	logic                   expired;
	logic                   in_frame_r;
	logic [8:0]             frame_age_r;

	// masked byte-lane merge, fixed bits forced
	function automatic hccfg_pkg::hccfg_word_t merge(input hccfg_pkg::hccfg_word_t old_v,
		input hccfg_pkg::hccfg_word_t new_v, input logic [3:0] be, input hccfg_pkg::hccfg_word_t wmask);
		hccfg_pkg::hccfg_word_t lanes;
		lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		merge = ((old_v & ~lanes) | (new_v & lanes)) & wmask;
	endfunction

	// dword decode; 0Ch and 0Eh share one dword
	function automatic logic dw_hit(input logic [7:0] addr, input logic [7:0] off);
		dw_hit = addr[7:2] == off[7:2];
	endfunction

	wire logic sel_dw0c = dw_hit(cfg_addr, `HCCFG_OFF_CACHE_LAT);
	wire logic sel_ctrl = dw_hit(cfg_addr, `HCCFG_OFF_CTRL_WIN);
	wire logic sel_ext  = dw_hit(cfg_addr, `HCCFG_OFF_EXT_WIN);

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			line_burst_length_r <= 8'(`HCCFG_CACHE_LAT_RST >> `HCCFG_LINE_LSB);
		end else if (cfg_wr && sel_dw0c && cfg_be[0]) begin
			line_burst_length_r <= cfg_wdata[7:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			lat_limit_r <= 8'(`HCCFG_CACHE_LAT_RST >> `HCCFG_LAT_LSB);
		end else if (cfg_wr && sel_dw0c && cfg_be[1]) begin
			lat_limit_r <= cfg_wdata[15:8];
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ctrl_base_r <= `HCCFG_WIN_RST;
		end else if (cfg_wr && sel_ctrl) begin
			ctrl_base_r <= merge(ctrl_base_r, cfg_wdata, cfg_be, `HCCFG_CTRL_WIN_MASK);
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ext_base_r <= `HCCFG_WIN_RST;
		end else if (cfg_wr && sel_ext) begin
			ext_base_r <= merge(ext_base_r, cfg_wdata, cfg_be, `HCCFG_EXT_WIN_MASK);
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cfg_rdata_r <= 32'h00000000;
			cfg_rvalid_r <= 1'b0;
		end else begin
			cfg_rvalid_r <= cfg_rd;
			if (cfg_rd) begin
				if (sel_dw0c) begin
					cfg_rdata_r <= {`HCCFG_HDR_SELFTEST_VAL, lat_limit_r, line_burst_length_r};
				end else if (sel_ctrl) begin
					cfg_rdata_r <= ctrl_base_r;
				end else if (sel_ext) begin
					cfg_rdata_r <= ext_base_r;
				end else begin
					cfg_rdata_r <= 32'h00000000;
				end
			end
		end
	end

	hccfg_lat_timer u_lat (
		.mclk        (mclk),
		.resetn      (resetn),
		.frame_start (frame_start),
		.frame_done  (frame_done),
		.limit       (lat_limit_r),
		.expired_r   (expired)
	);

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			end_xfer_r <= 1'b0;
		end else begin
			end_xfer_r <= expired && !gnt_active && !frame_done;
		end
	end

	// frame age for checks
	// saturates so a stuck frame never wraps
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			in_frame_r  <= 1'b0;
			frame_age_r <= 9'h000;
		end else if (!in_frame_r) begin
			in_frame_r  <= frame_start;
			frame_age_r <= 9'h000;
		end else if (frame_done) begin
			in_frame_r <= 1'b0;
		end else if (frame_age_r != 9'h1ff) begin
			frame_age_r <= frame_age_r + 9'h001;
		end
	end

	property p_ctrl_ones;
		@(posedge mclk) disable iff (!resetn)
		(cfg_wr && sel_ctrl && cfg_be == 4'hf && cfg_wdata == 32'hffffffff) |=> ctrl_base_r == 32'hfffff800;
	endproperty
	a_ctrl_ones: assert property (p_ctrl_ones) else $error("control window size wrong");

	property p_ext_ones;
		@(posedge mclk) disable iff (!resetn)
		(cfg_wr && sel_ext && cfg_be == 4'hf && cfg_wdata == 32'hffffffff) |=> ext_base_r == 32'hffffc000;
	endproperty
	a_ext_ones: assert property (p_ext_ones) else $error("extension window size wrong");

	property p_ctrl_low;
		@(posedge mclk) disable iff (!resetn)
		ctrl_base_r[10:0] == 11'h000;
	endproperty
	a_ctrl_low: assert property (p_ctrl_low) else $error("control low bits nonzero");

	property p_ctrl_ptr;
		@(posedge mclk) disable iff (!resetn)
		(cfg_wr && sel_ctrl && cfg_be == 4'hf) |=> ctrl_base_r[31:11] == $past(cfg_wdata[31:11]);
	endproperty
	a_ctrl_ptr: assert property (p_ctrl_ptr) else $error("control pointer not stored");

	property p_ext_ptr;
		@(posedge mclk) disable iff (!resetn)
		(cfg_wr && sel_ext && cfg_be == 4'hf) |=> ext_base_r[31:14] == $past(cfg_wdata[31:14]);
	endproperty
	a_ext_ptr: assert property (p_ext_ptr) else $error("extension pointer not stored");

	property p_ext_low;
		@(posedge mclk) disable iff (!resetn)
		ext_base_r[13:0] == 14'h0000;
	endproperty
	a_ext_low: assert property (p_ext_low) else $error("extension low bits nonzero");

	property p_hdr_zero;
		@(posedge mclk) disable iff (!resetn)
		(cfg_rd && sel_dw0c) |=> cfg_rvalid_r && cfg_rdata_r[31:16] == 16'h0000;
	endproperty
	a_hdr_zero: assert property (p_hdr_zero) else $error("header or self-test nonzero");

	property p_line_wr;
		@(posedge mclk) disable iff (!resetn)
		(cfg_wr && sel_dw0c && cfg_be[0]) |=> line_burst_length_r == $past(cfg_wdata[7:0]);
	endproperty
	a_line_wr: assert property (p_line_wr) else $error("line size not stored");

	property p_end_xfer;
		@(posedge mclk) disable iff (!resetn)
		(expired && !gnt_active && !frame_done) |=> end_xfer_r;
	endproperty
	a_end_xfer: assert property (p_end_xfer) else $error("no termination after expiry");

	sequence s_expired_window;
		in_frame_r && !frame_done && frame_age_r > {1'b0, lat_limit_r};
	endsequence

	sequence s_grant_gone;
		!gnt_active;
	endsequence

	sequence s_dw0c_read;
		cfg_rd && sel_dw0c;
	endsequence

	sequence s_ctrl_read;
		cfg_rd && sel_ctrl;
	endsequence

	sequence s_ext_read;
		cfg_rd && sel_ext;
	endsequence

	property p_end_due;
		@(posedge mclk) disable iff (!resetn)
		s_expired_window ##0 s_grant_gone |=> end_xfer_r;
	endproperty
	a_end_due: assert property (p_end_due) else $error("termination missing after count and grant loss");

	property p_end_early;
		@(posedge mclk) disable iff (!resetn)
		end_xfer_r |-> $past(in_frame_r) && !$past(gnt_active)
			&& $past(frame_age_r) >= {1'b0, $past(lat_limit_r)};
	endproperty
	a_end_early: assert property (p_end_early) else $error("termination before count or with grant");

	property p_lat_wr;
		@(posedge mclk) disable iff (!resetn)
		(cfg_wr && sel_dw0c && cfg_be[1]) |=> lat_limit_r == $past(cfg_wdata[15:8]);
	endproperty
	a_lat_wr: assert property (p_lat_wr) else $error("latency field not stored");

	property p_line_keep;
		@(posedge mclk) disable iff (!resetn)
		(cfg_wr && sel_dw0c && !cfg_be[0]) |=> $stable(line_burst_length_r);
	endproperty
	a_line_keep: assert property (p_line_keep) else $error("line size changed without its lane");

	property p_ctrl_keep;
		@(posedge mclk) disable iff (!resetn)
		(cfg_wr && sel_ctrl && !cfg_be[3]) |=> ctrl_base_r[31:24] == $past(ctrl_base_r[31:24]);
	endproperty
	a_ctrl_keep: assert property (p_ctrl_keep) else $error("control top byte changed without its lane");

	property p_ext_keep;
		@(posedge mclk) disable iff (!resetn)
		(cfg_wr && sel_ext && !cfg_be[2]) |=> ext_base_r[23:16] == $past(ext_base_r[23:16]);
	endproperty
	a_ext_keep: assert property (p_ext_keep) else $error("extension byte changed without its lane");

	property p_ctrl_idle;
		@(posedge mclk) disable iff (!resetn)
		!(cfg_wr && sel_ctrl) |=> $stable(ctrl_base_r);
	endproperty
	a_ctrl_idle: assert property (p_ctrl_idle) else $error("control window changed without write");

	property p_rd_ctrl;
		@(posedge mclk) disable iff (!resetn)
		s_ctrl_read |=> cfg_rdata_r == $past(ctrl_base_r);
	endproperty
	a_rd_ctrl: assert property (p_rd_ctrl) else $error("control window readback wrong");

	property p_rd_ext;
		@(posedge mclk) disable iff (!resetn)
		s_ext_read |=> cfg_rdata_r == $past(ext_base_r);
	endproperty
	a_rd_ext: assert property (p_rd_ext) else $error("extension window readback wrong");

	property p_hdr_type;
		@(posedge mclk) disable iff (!resetn)
		s_dw0c_read |=> cfg_rdata_r[23:16] == 8'h00;
	endproperty
	a_hdr_type: assert property (p_hdr_type) else $error("header type byte nonzero");

	property p_line_rd;
		@(posedge mclk) disable iff (!resetn)
		s_dw0c_read |=> cfg_rdata_r[15:0] == $past({lat_limit_r, line_burst_length_r});
	endproperty
	a_line_rd: assert property (p_line_rd) else $error("latency or line size readback wrong");
endmodule // hccfg_regs
`default_nettype wire

// ---- sim/hccfg_arb.sv ----
/*
 bus arbiter model: holds grant, withdraws it DLY+1 cycles after drop.
 assumes the bench clock and sync reset.
*/
`timescale 1ns/1ps
`default_nettype none
module hccfg_arb #(parameter int DLY = 1) (
	input  wire logic mclk,
	input  wire logic resetn,
	input  wire logic drop,
	output var  logic gnt_active
);
	logic [7:0] cnt_r;
	always_ff @(posedge mclk) begin
		if (!resetn || !drop) begin
			cnt_r      <= 8'h00;
			gnt_active <= resetn;
		end else if (cnt_r == 8'(DLY)) begin
			gnt_active <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
endmodule // hccfg_arb
`default_nettype wire

// ---- sim/tb_top.sv ----
/*
 self-checking bench of the config header slice, with a reference model.
 assumes hccfg_regs and the arbiter model.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic                   mclk, resetn, cfg_wr, cfg_rd, frame_start, frame_done, drop;
	logic                   cfg_rvalid_r, end_xfer_r, gnt_active, seen;
	logic [7:0]             cfg_addr;
	logic [3:0]             cfg_be;
	hccfg_pkg::hccfg_word_t cfg_wdata, cfg_rdata_r, ctrl_base_r, ext_base_r, m_lat, m_ctrl, m_ext;
	hccfg_pkg::hccfg_byte_t line_burst_length_r;
	int                     n_mismatch, compares, cyc, n;
	logic [7:0]             ads [4] = '{8'h0c, 8'h10, 8'h14, 8'h18};

	hccfg_regs dut (.mclk, .resetn, .cfg_addr, .cfg_be, .cfg_wr, .cfg_rd, .cfg_wdata, .frame_start,
		.frame_done, .gnt_active, .cfg_rdata_r, .cfg_rvalid_r, .end_xfer_r, .line_burst_length_r,
		.ctrl_base_r, .ext_base_r);
	hccfg_arb #(.DLY(1)) arb (.mclk, .resetn, .drop, .gnt_active);

	task automatic close_out;
		$display("mismatches=%0d compares=%0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input hccfg_pkg::hccfg_word_t got, input hccfg_pkg::hccfg_word_t exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// byte lanes, read-only bits kept at zero
	function automatic hccfg_pkg::hccfg_word_t upd(input hccfg_pkg::hccfg_word_t o, d, k, input logic [3:0] be);
		for (int i = 0; i < 4; i++)
			if (be[i])
				o[i*8+:8] = d[i*8+:8] & k[i*8+:8];
		return o;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input hccfg_pkg::hccfg_word_t d);
		@(posedge mclk);
		cfg_wr    <= 1'b1;
		cfg_addr  <= a;
		cfg_be    <= be;
		cfg_wdata <= d;
		@(posedge mclk);
		cfg_wr <= 1'b0;
		case (a[7:2])
			6'h03: m_lat = upd(m_lat, d, 32'h0000ffff, be);
			6'h04: m_ctrl = upd(m_ctrl, d, 32'hfffff800, be);
			6'h05: m_ext = upd(m_ext, d, 32'hffffc000, be);
			default: ;
		endcase
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		cfg_rd   <= 1'b1;
		cfg_addr <= a;
		@(posedge mclk);
		cfg_rd <= 1'b0;
		#1;
		chk({31'h0, cfg_rvalid_r}, 32'h1);
		chk(cfg_rdata_r, a[7:2] == 6'h03 ? m_lat : a[7:2] == 6'h04 ? m_ctrl : a[7:2] == 6'h05 ? m_ext : 32'h0);
	endtask
	// hold keeps grant through 8 checked cycles past start, then drop rises, else drop rises with start; grant falls two cycles after drop
	task automatic lat(input logic [7:0] l, input logic hold);
		wr(8'h0c, 4'h2, {16'h0, l, 8'h00});
		@(posedge mclk);
		frame_start <= 1'b1;
		drop        <= !hold;
		@(posedge mclk);
		frame_start <= 1'b0;
		n    = 0;
		seen = 1'b0;
		if (hold) begin
			repeat (8) begin
				@(posedge mclk);
				#1;
				seen |= end_xfer_r;
			end
			chk({31'h0, seen}, 32'h0);
			@(posedge mclk);
			drop <= 1'b1;
		end
		while (end_xfer_r !== 1'b1 && n < 40) begin
			@(posedge mclk);
			n++;
			#1;
		end
		chk(n, hold ? 3 : l + 1);
		@(posedge mclk);
		frame_done <= 1'b1;
		@(posedge mclk);
		frame_done <= 1'b0;
		drop       <= 1'b0;
		@(posedge mclk);
		#1;
		chk({31'h0, end_xfer_r}, 32'h0);
	endtask

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// hang guard, run needs well under this
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			close_out;
		end
	end
	initial begin
		{resetn, cfg_wr, cfg_rd, frame_start, frame_done, drop} = '0;
		{cfg_addr, cfg_be, cfg_wdata} = '0;
		{m_lat, m_ctrl, m_ext} = '0;
		void'($urandom(28));
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		foreach (ads[i]) rd(ads[i]);
		wr(8'h10, 4'hf, '1);
		wr(8'h14, 4'hf, '1);
		wr(8'h0c, 4'hf, '1);
		rd(8'h10);
		rd(8'h14);
		rd(8'h0e);
		chk({24'h0, line_burst_length_r}, 32'hff);
		chk(ctrl_base_r, m_ctrl);
		chk(ext_base_r, m_ext);
		repeat (30) begin
			wr(ads[$urandom % 4], 4'($urandom), $urandom);
			rd(ads[$urandom % 4]);
		end
		lat(8'h03, 1'b0);
		lat(8'h06, 1'b0);
		lat(8'h03, 1'b1);
		close_out;
	end
endmodule // tb_top
`default_nettype wire
